// file: include/pmj_pkg.sv
// How it works
// - Monitor selection 15 shows load-to-motor inertia ratio in tenths.
// - Selection 17 shows first resonance in low half, second in high half.
// - Selection 18 shows signed encoder position from index home, -5000 to +5000.
// - Sixteen-bit decimal values fill five digits with leading zeros.
// - Sixteen-bit hex values show four hex digits, no prefix or sign.
// - Thirty-two-bit decimal: low view lowest five digits, high view rest with point.
// - Thirty-two-bit hex: high half after letter h, low half after letter L.
// - Negative decimal lights two leftmost points; hex never shows a sign.
// - Same formatting serves monitor view and parameter views.
// - Monitor values are 32-bit with free half and radix choice, except selection 17, shown 16-bit.
// - Set on a fault record parameter shows that stored fault code.
// - Set on the jog parameter shows jog speed, default 20 r/min.
// - Up and down change jog speed; shift moves the blinking digit.
// - Set accepts the speed, shows the jog text and enters jog run.
// - In jog run, up turns one way, down the other, none stops.
// - Mode in jog run returns to the jog parameter name.
// - Jog motion only while the drive is servo-on.
// - Writing 406 to the special function code enables forced outputs.
// - Each forced value bit drives one output, bit 0 the first.
// - Forced value and mode are volatile and clear at power-up.
// - Writing 400 to the special function code switches forced mode.
// - Forcing acts only while servo is off.
package pmj_pkg;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_FREQ_HZ    = 40_000_000;
   localparam int BLINK_HALF_MS  = 250;
   localparam int BLINK_HALF_CYC = CLK_FREQ_HZ / 1000 * BLINK_HALF_MS;
   localparam int BLINK_W        = 24;

   // ----------------------------------------
   // Selections, codes, reset values
   // ----------------------------------------
   localparam logic [4:0]  SEL_INERTIA      = 5'h0F;
   localparam logic [4:0]  SEL_RESON        = 5'h11;
   localparam logic [4:0]  SEL_ZPOS         = 5'h12;
   localparam logic [15:0] SFC_FORCE_ON     = 16'h0196;
   localparam logic [15:0] SFC_FORCE_SWITCH = 16'h0190;
   localparam logic [15:0] JOG_SPEED_RST    = 16'h0014;
   localparam logic [15:0] JOG_SPEED_MAX    = 16'h1388;
   localparam logic [2:0]  DIGIT_RST        = 3'h0;
   localparam logic [2:0]  DIGIT_LAST       = 3'h4;
   localparam int          NUM_DO           = 3;
   localparam int          FAULT_DEPTH      = 5;

   // ----------------------------------------
   // Display glyphs, 5 bits a digit
   // ----------------------------------------
   localparam logic [4:0]  G_H     = 5'h10;
   localparam logic [4:0]  G_L     = 5'h11;
   localparam logic [4:0]  G_BLANK = 5'h12;
   localparam logic [4:0]  G_J     = 5'h13;
   localparam logic [4:0]  G_G     = 5'h14;
   localparam logic [4:0]  G_P     = 5'h15;
   localparam logic [24:0] JOG_TEXT = {G_BLANK, G_BLANK, G_J, 5'h00, G_G};
   localparam logic [24:0] JOG_NAME_TEXT = {G_P, 5'h04, G_BLANK, 5'h00, 5'h05};

   typedef enum logic [2:0] {
      ST_MONITOR,
      ST_FAULT_VIEW,
      ST_JOG_EDIT,
      ST_JOG_RUN,
      ST_JOG_NAME
   } pmj_state_e;

endpackage : pmj_pkg

// file: logic/pmj_fmt.sv
`timescale 1ns/1ps
module pmj_fmt (
   // Value and view choice
   input  wire logic [31:0] value,
   input  wire logic        is_signed,
   input  wire logic        hex,
   input  wire logic        high,
   input  wire logic        wide,
   // Five glyphs, leftmost in top bits
   output logic      [24:0] glyph,
   output logic      [4:0]  dp
);
   import pmj_pkg::*;

   // ----------------------------------------
   // Binary to packed decimal
   // ----------------------------------------
   function automatic logic [39:0] pmj_bcd(input logic [31:0] bin);
      logic [39:0] b;
      b = '0;
      for (int i = 31; i >= 0; i--) begin
         for (int j = 0; j < 10; j++) begin
            if (b[j*4 +: 4] > 4'h4) begin
               b[j*4 +: 4] = b[j*4 +: 4] + 4'h3;
            end
         end
         b = {b[38:0], bin[i]};
      end
      return b;
   endfunction : pmj_bcd

   logic        neg;
   logic [31:0] mag;
   logic [39:0] bcd;

   // Sign only matters for decimal; hex shows raw bits
   assign neg = is_signed && value[31] && !hex;
   assign mag = neg ? (~value + 32'h0000_0001) : value;
   assign bcd = pmj_bcd(mag);

   // Glyph selection, shared by every view
   always_comb begin
      glyph = '0;
      dp    = '0;
      if (hex) begin
         if (!wide) begin
            glyph = {G_BLANK, 1'b0, value[15:12], 1'b0, value[11:8],
                     1'b0, value[7:4], 1'b0, value[3:0]};
         end else if (high) begin
            glyph = {G_H, 1'b0, value[31:28], 1'b0, value[27:24],
                     1'b0, value[23:20], 1'b0, value[19:16]};
         end else begin
            glyph = {G_L, 1'b0, value[15:12], 1'b0, value[11:8],
                     1'b0, value[7:4], 1'b0, value[3:0]};
         end
      end else begin
         if (wide && high) begin
            glyph = {1'b0, bcd[39:36], 1'b0, bcd[35:32], 1'b0, bcd[31:28],
                     1'b0, bcd[27:24], 1'b0, bcd[23:20]};
            dp[0] = 1'b1;
         end else begin
            glyph = {1'b0, bcd[19:16], 1'b0, bcd[15:12], 1'b0, bcd[11:8],
                     1'b0, bcd[7:4], 1'b0, bcd[3:0]};
         end
         dp[4:3] = {neg, neg};
      end
   end

endmodule : pmj_fmt

// file: logic/pmj_panel.sv
`timescale 1ns/1ps
module pmj_panel #(
   parameter int BLINK_CYC = pmj_pkg::BLINK_HALF_CYC
) (
   // Clock, reset, enable
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        clk_en,
   // Front-panel keys, raw pins
   input  wire logic        key_up,
   input  wire logic        key_down,
   input  wire logic        key_shift,
   input  wire logic        key_set,
   input  wire logic        key_mode,
   // Menu position from parameter navigation
   input  wire logic        menu_fault,
   input  wire logic [2:0]  fault_index,
   input  wire logic        menu_jog,
   // Monitor quantities from the motion core
   input  wire logic [4:0]  monitor_select,
   input  wire logic        disp_hex,
   input  wire logic        disp_high,
   input  wire logic [31:0] mon_value,
   input  wire logic [15:0] inertia_x10,
   input  wire logic [15:0] reson_first,
   input  wire logic [15:0] reson_second,
   input  wire logic [13:0] zpos,
   // Fault reporting
   input  wire logic        fault_event,
   input  wire logic [7:0]  fault_code,
   // Drive status and function outputs
   input  wire logic        servo_on,
   input  wire logic [2:0]  do_function_state,
   // Special function and forced value writes
   input  wire logic        sfc_write,
   input  wire logic [15:0] special_function_code,
   input  wire logic        fov_write,
   input  wire logic [2:0]  forced_output_value,
   // Display
   output logic      [24:0] disp_glyph,
   output logic      [4:0]  disp_dp,
   // Jog command
   output logic             jog_fwd,
   output logic             jog_rev,
   output logic      [15:0] jog_speed,
   // Digital outputs
   output logic             force_active,
   output logic             digital_output_one,
   output logic             digital_output_two,
   output logic             digital_output_three
);
   import pmj_pkg::*;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [15:0] pmj_pow10(input logic [2:0] idx);
      case (idx)
         3'h0:    return 16'h0001;
         3'h1:    return 16'h000A;
         3'h2:    return 16'h0064;
         3'h3:    return 16'h03E8;
         default: return 16'h2710;
      endcase
   endfunction : pmj_pow10

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   pmj_state_e           st;
   pmj_state_e           next_st;
   logic [4:0]           key_meta;
   logic [4:0]           key_sync;
   logic [4:0]           key_prev;
   logic [4:0]           key_pulse;
   logic                 up_p;
   logic                 down_p;
   logic                 shift_p;
   logic                 set_p;
   logic                 mode_p;
   logic [15:0]          jog_edit;
   logic [2:0]           cur_digit;
   logic [16:0]          inc_sum;
   logic [15:0]          step;
   logic [BLINK_W-1:0]   blink_cnt;
   logic                 blink;
   logic [7:0]           fault_log [FAULT_DEPTH];
   logic [2:0]           fault_pick;
   logic                 force_en;
   logic [NUM_DO-1:0]    fov;
   logic [NUM_DO-1:0]    do_q;
   logic                 run_ok;
   logic [31:0]          fmt_val;
   logic                 fmt_signed;
   logic                 fmt_hex;
   logic                 fmt_high;
   logic                 fmt_wide;
   logic [24:0]          fmt_glyph;
   logic [4:0]           fmt_dp;
   logic [24:0]          next_glyph;

   // ----------------------------------------
   // Key synchroniser and press edges
   // ----------------------------------------
   // Keys are asynchronous pins; two stages before any use
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         key_meta <= '0;
         key_sync <= '0;
         key_prev <= '0;
      end else if (clk_en) begin
         key_meta <= {key_mode, key_set, key_shift, key_down, key_up};
         key_sync <= key_meta;
         key_prev <= key_sync;
      end
   end

   assign key_pulse = key_sync & ~key_prev;
   assign up_p      = key_pulse[0];
   assign down_p    = key_pulse[1];
   assign shift_p   = key_pulse[2];
   assign set_p     = key_pulse[3];
   assign mode_p    = key_pulse[4];

   // ----------------------------------------
   // Panel state machine
   // ----------------------------------------
   always_comb begin
      next_st = st;
      case (st)
         ST_MONITOR: begin
            if (set_p && menu_jog) begin
               next_st = ST_JOG_EDIT;
            end else if (set_p && menu_fault) begin
               next_st = ST_FAULT_VIEW;
            end
         end
         ST_FAULT_VIEW: begin
            if (mode_p) begin
               next_st = ST_MONITOR;
            end
         end
         ST_JOG_EDIT: begin
            if (set_p) begin
               next_st = ST_JOG_RUN;
            end else if (mode_p) begin
               next_st = ST_JOG_NAME;
            end
         end
         ST_JOG_RUN: begin
            if (mode_p) begin
               next_st = ST_JOG_NAME;
            end
         end
         ST_JOG_NAME: begin
            if (set_p) begin
               next_st = ST_JOG_EDIT;
            end else if (mode_p || !menu_jog) begin
               next_st = ST_MONITOR;
            end
         end
         default: next_st = ST_MONITOR;
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st <= ST_MONITOR;
      end else if (clk_en) begin
         st <= next_st;
      end
   end

   // ----------------------------------------
   // Jog speed editing
   // ----------------------------------------
   assign step    = pmj_pow10(cur_digit);
   assign inc_sum = {1'b0, jog_edit} + {1'b0, step};

   // Saturate rather than wrap so a slip never jumps the speed
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         jog_edit  <= JOG_SPEED_RST;
         cur_digit <= DIGIT_RST;
      end else if (clk_en && st == ST_JOG_EDIT) begin
         if (up_p) begin
            jog_edit <= (inc_sum > {1'b0, JOG_SPEED_MAX}) ? JOG_SPEED_MAX
                                                          : inc_sum[15:0];
         end else if (down_p) begin
            jog_edit <= (jog_edit < step) ? 16'h0000 : jog_edit - step;
         end
         if (shift_p) begin
            cur_digit <= (cur_digit == DIGIT_LAST) ? DIGIT_RST
                                                   : cur_digit + 3'h1;
         end
      end
   end

   // Accepted speed only changes on set
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         jog_speed <= JOG_SPEED_RST;
      end else if (clk_en && st == ST_JOG_EDIT && set_p) begin
         jog_speed <= jog_edit;
      end
   end

   // ----------------------------------------
   // Jog motion
   // ----------------------------------------
   assign run_ok = (st == ST_JOG_RUN) && servo_on;

   // Both keys held counts as neither
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         jog_fwd <= 1'b0;
         jog_rev <= 1'b0;
      end else if (clk_en) begin
         jog_fwd <= run_ok && key_sync[0] && !key_sync[1];
         jog_rev <= run_ok && key_sync[1] && !key_sync[0];
      end
   end

   // ----------------------------------------
   // Digit blink timer
   // ----------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         blink_cnt <= '0;
         blink     <= 1'b0;
      end else if (clk_en) begin
         if (blink_cnt == BLINK_W'(BLINK_CYC - 1)) begin
            blink_cnt <= '0;
            blink     <= !blink;
         end else begin
            blink_cnt <= blink_cnt + 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Fault history, newest at entry 0
   // ----------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < FAULT_DEPTH; i++) begin
            fault_log[i] <= '0;
         end
      end else if (clk_en && fault_event) begin
         fault_log[0] <= fault_code;
         for (int i = 1; i < FAULT_DEPTH; i++) begin
            fault_log[i] <= fault_log[i-1];
         end
      end
   end

   // Out-of-range index shows the oldest entry
   assign fault_pick = (fault_index > 3'(FAULT_DEPTH - 1)) ? 3'(FAULT_DEPTH - 1)
                                                          : fault_index;

   // ----------------------------------------
   // Forced output control
   // ----------------------------------------
   // Volatile by design: power-up reset clears both mode and value
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         force_en <= 1'b0;
      end else if (clk_en && sfc_write) begin
         if (special_function_code == SFC_FORCE_ON) begin
            force_en <= 1'b1;
         end else if (special_function_code == SFC_FORCE_SWITCH) begin
            force_en <= !force_en;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         fov <= '0;
      end else if (clk_en && fov_write) begin
         fov <= forced_output_value;
      end
   end

   // Servo-on always hands outputs back to their functions
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         do_q         <= '0;
         force_active <= 1'b0;
      end else if (clk_en) begin
         force_active <= force_en && !servo_on;
         do_q <= (force_en && !servo_on) ? fov
                                        : do_function_state;
      end
   end

   assign digital_output_one   = do_q[0];
   assign digital_output_two   = do_q[1];
   assign digital_output_three = do_q[2];

   // ----------------------------------------
   // Value selection for the formatter
   // ----------------------------------------
   always_comb begin
      fmt_val    = mon_value;
      fmt_signed = 1'b1;
      fmt_hex    = disp_hex;
      fmt_high   = disp_high;
      fmt_wide   = 1'b1;
      case (st)
         ST_FAULT_VIEW: begin
            fmt_val    = {24'h00_0000, fault_log[fault_pick]};
            fmt_signed = 1'b0;
            fmt_hex    = 1'b1;
            fmt_wide   = 1'b0;
         end
         ST_JOG_EDIT: begin
            fmt_val    = {16'h0000, jog_edit};
            fmt_signed = 1'b0;
            fmt_hex    = 1'b0;
            fmt_wide   = 1'b0;
         end
         default: begin
            if (monitor_select == SEL_INERTIA) begin
               fmt_val = {16'h0000, inertia_x10};
            end else if (monitor_select == SEL_RESON) begin
               // Halves are separate quantities, so each is its own view
               fmt_val    = {16'h0000, disp_high ? reson_second
                                                 : reson_first};
               fmt_signed = 1'b0;
               fmt_wide   = 1'b0;
            end else if (monitor_select == SEL_ZPOS) begin
               fmt_val = {{18{zpos[13]}}, zpos};
            end
         end
      endcase
   end

   pmj_fmt u_fmt (
      .value     (fmt_val),
      .is_signed (fmt_signed),
      .hex       (fmt_hex),
      .high      (fmt_high),
      .wide      (fmt_wide),
      .glyph     (fmt_glyph),
      .dp        (fmt_dp)
   );

   // ----------------------------------------
   // Display register
   // ----------------------------------------
   always_comb begin
      next_glyph = fmt_glyph;
      if (st == ST_JOG_EDIT && blink) begin
         next_glyph[cur_digit*5 +: 5] = G_BLANK;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         disp_glyph <= {5{G_BLANK}};
         disp_dp    <= '0;
      end else if (clk_en) begin
         case (st)
            ST_JOG_RUN: begin
               disp_glyph <= JOG_TEXT;
               disp_dp    <= '0;
            end
            ST_JOG_NAME: begin
               disp_glyph <= JOG_NAME_TEXT;
               disp_dp    <= '0;
            end
            default: begin
               disp_glyph <= next_glyph;
               disp_dp    <= fmt_dp;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   a_jog_servo_gate: assert property ((jog_fwd || jog_rev) && $past(clk_en) |-> $past(servo_on))
      else $error("jog moved without servo-on");
   a_jog_one_way: assert property (!(jog_fwd && jog_rev))
      else $error("jog both directions");
   a_jog_stop_leave: assert property ($past(clk_en) && $past(st) != ST_JOG_RUN |-> !jog_fwd && !jog_rev)
      else $error("jog outside run state");
   a_jog_key_dir: assert property (clk_en && run_ok && key_sync == 5'h01 |=> jog_fwd)
      else $error("up key did not jog");
   a_force_on_code: assert property (clk_en && sfc_write && special_function_code == SFC_FORCE_ON |=> force_en)
      else $error("force not enabled");
   a_force_switch: assert property (clk_en && sfc_write && special_function_code == SFC_FORCE_SWITCH
                                    |=> force_en != $past(force_en))
      else $error("force mode not switched");
   a_force_drives: assert property (clk_en && force_en && !servo_on
                                    |=> digital_output_two == $past(fov[1]) && force_active)
      else $error("forced bit not driven");
   a_normal_drives: assert property (clk_en && (!force_en || servo_on)
                                     |=> do_q == $past(do_function_state))
      else $error("outputs not from functions");
   a_set_run: assert property (clk_en && st == ST_JOG_EDIT && set_p
                               |=> st == ST_JOG_RUN && jog_speed == $past(jog_edit))
      else $error("set did not start jog run");
   a_mode_name: assert property (clk_en && st == ST_JOG_RUN && mode_p |=> st == ST_JOG_NAME ##1 1 [*1])
      else $error("mode did not leave jog run");
   a_speed_limit: assert property (jog_edit <= JOG_SPEED_MAX)
      else $error("jog speed above limit");

   c_jog_fwd: cover property (jog_fwd ##1 !jog_fwd);
   c_fault_view: cover property (st == ST_FAULT_VIEW);
   c_force_live: cover property (force_active && do_q != do_function_state);

endmodule : pmj_panel

// file: sim/pmj_operator.sv
`timescale 1ns/1ps
// ----------------------------------------
// Operator at the front-panel keys
// ----------------------------------------
module pmj_operator (
   // Clock
   input  wire logic clk,
   // Keys, released keys sit low
   output logic      key_up,
   output logic      key_down,
   output logic      key_shift,
   output logic      key_set,
   output logic      key_mode
);
   logic [4:0] keys = 5'h00;

   // Key order: up, down, shift, set, mode
   assign {key_mode, key_set, key_shift, key_down, key_up} = keys;

   // One press, long enough to pass the two-stage sync
   task press(input int k);
      @(posedge clk);
      keys[k] <= 1'b1;
      repeat (4) @(posedge clk);
      keys[k] <= 1'b0;
      repeat (4) @(posedge clk);
   endtask : press

   // Held level for jog runs
   task hold(input int k, input logic lvl);
      @(posedge clk);
      keys[k] <= lvl;
   endtask : hold
endmodule : pmj_operator

// file: sim/pmj_panel_test.sv
`timescale 1ns/1ps
module pmj_panel_test;
   import pmj_pkg::*;
   logic clk = 0, nrst = 0, menu_fault = 0, menu_jog = 0, disp_hex = 0, disp_high = 0, fault_event = 0;
   logic servo_on = 0, sfc_write = 0, fov_write = 0, clk_en = 1, key_up, key_down, key_shift, key_set, key_mode;
   logic [2:0]  fault_index = 3'h0, do_function_state = 3'h5, forced_output_value = 3'h0;
   logic [4:0]  monitor_select = 5'h00;
   logic [31:0] mon_value = 32'h0000_0000;
   logic [15:0] special_function_code = 16'h0000;
   logic [7:0]  fault_code = 8'hAB;
   logic [24:0] disp_glyph;
   logic [4:0]  disp_dp;
   logic [15:0] jog_speed;
   logic        jog_fwd, jog_rev, force_active, digital_output_one, digital_output_two, digital_output_three;
   int          n_fail = 0, check_count = 0;
   logic [2:0]  dout;

   assign dout = {digital_output_three, digital_output_two, digital_output_one};
   always #12.5 clk = ~clk;

   pmj_operator i_pmj_operator (.clk(clk), .key_up(key_up), .key_down(key_down), .key_shift(key_shift),
      .key_set(key_set), .key_mode(key_mode));
   pmj_panel #(.BLINK_CYC(4)) i_pmj_panel (.clk(clk), .nrst(nrst), .clk_en(clk_en), .key_up(key_up),
      .key_down(key_down), .key_shift(key_shift), .key_set(key_set), .key_mode(key_mode),
      .menu_fault(menu_fault), .fault_index(fault_index), .menu_jog(menu_jog), .monitor_select(monitor_select),
      .disp_hex(disp_hex), .disp_high(disp_high), .mon_value(mon_value), .inertia_x10(mon_value[31:16]),
      .reson_first(mon_value[15:0]), .reson_second(mon_value[31:16]), .zpos(mon_value[13:0]), .fault_event(fault_event),
      .fault_code(fault_code), .servo_on(servo_on), .do_function_state(do_function_state),
      .sfc_write(sfc_write), .special_function_code(special_function_code), .fov_write(fov_write),
      .forced_output_value(forced_output_value), .disp_glyph(disp_glyph), .disp_dp(disp_dp),
      .jog_fwd(jog_fwd), .jog_rev(jog_rev), .jog_speed(jog_speed), .force_active(force_active),
      .digital_output_one(digital_output_one), .digital_output_two(digital_output_two),
      .digital_output_three(digital_output_three));

   // ----------------------------------------
   // Shared helpers
   // ----------------------------------------
   task chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // Lead glyph then four hex digit glyphs
   function logic [24:0] gl(input logic [4:0] lead, input logic [15:0] n);
      gl = {lead, 1'b0, n[15:12], 1'b0, n[11:8], 1'b0, n[7:4], 1'b0, n[3:0]};
   endfunction : gl

   task show(input logic [4:0] s, input logic h, input logic hi, input logic [31:0] v,
             input logic [24:0] g, input logic [4:0] d);
      @(posedge clk);
      monitor_select <= s;
      disp_hex <= h;
      disp_high <= hi;
      mon_value <= v;
      repeat (3) @(posedge clk);
      #1;
      chk({7'h00, disp_glyph}, {7'h00, g});
      chk({27'h000_0000, disp_dp}, {27'h000_0000, d});
   endtask : show

   // One-cycle write pulse, code or forced value
   task wr(input logic is_sfc, input logic [15:0] v);
      @(posedge clk);
      if (is_sfc) begin
         sfc_write <= 1'b1;
         special_function_code <= v;
      end else begin
         fov_write <= 1'b1;
         forced_output_value <= v[2:0];
      end
      @(posedge clk);
      sfc_write <= 1'b0;
      fov_write <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
   endtask : wr

   task print_verdict;
      $display("checks=%0d fails=%0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : print_verdict

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_format;
      show(5'h00, 0, 0, 32'h0000_04D2, gl(5'h00, 16'h1234), 5'h00);
      show(5'h00, 1, 1, 32'h1234_5678, gl(G_H, 16'h1234), 5'h00);
      show(5'h00, 1, 0, 32'h1234_5678, gl(G_L, 16'h5678), 5'h00);
      show(5'h00, 0, 1, 32'h4996_02D2, gl(5'h01, 16'h2345), 5'h01);
      show(5'h00, 0, 0, 32'h4996_02D2, gl(5'h06, 16'h7890), 5'h00);
      show(5'h00, 0, 0, 32'hFFFF_CFC7, gl(5'h01, 16'h2345), 5'h18);
      show(5'h00, 1, 0, 32'hFFFF_FFFF, gl(G_L, 16'hFFFF), 5'h00);
      show(5'h0F, 0, 0, 32'h0082_0000, gl(5'h00, 16'h0130), 5'h00);
      show(5'h11, 0, 0, 32'h00A5_0032, gl(5'h00, 16'h0050), 5'h00);
      show(5'h11, 1, 1, 32'h00A5_0032, gl(G_BLANK, 16'h00A5), 5'h00);
      show(5'h12, 0, 0, 32'h0000_2C78, gl(5'h00, 16'h5000), 5'h18);
      clk_en <= 1'b0;
      show(5'h00, 0, 0, 32'h0000_04D2, gl(5'h00, 16'h5000), 5'h18); // Frozen
      clk_en <= 1'b1;
   endtask : t_format

   task t_jog;
      menu_jog <= 1'b1;
      servo_on <= 1'b1;
      i_pmj_operator.press(3);
      #1;
      chk({12'h000, disp_glyph[24:5]}, 32'h0000_0002);
      i_pmj_operator.press(0);
      i_pmj_operator.press(2);
      i_pmj_operator.press(0);
      i_pmj_operator.press(3);
      #1;
      chk({16'h0000, jog_speed}, 32'h0000_001F);
      chk({7'h00, disp_glyph}, {7'h00, JOG_TEXT});
      i_pmj_operator.hold(0, 1'b1);
      repeat (4) @(posedge clk);
      #1;
      chk({30'h0000_0000, jog_fwd, jog_rev}, 32'h0000_0002);
      i_pmj_operator.hold(0, 1'b0);
      i_pmj_operator.hold(1, 1'b1);
      repeat (4) @(posedge clk);
      #1;
      chk({30'h0000_0000, jog_fwd, jog_rev}, 32'h0000_0001);
      servo_on <= 1'b0;
      repeat (4) @(posedge clk);
      #1;
      chk({30'h0000_0000, jog_fwd, jog_rev}, 32'h0000_0000);
      i_pmj_operator.hold(1, 1'b0);
      servo_on <= 1'b1;
      i_pmj_operator.press(4);
      #1;
      chk({7'h00, disp_glyph}, {7'h00, JOG_NAME_TEXT});
      menu_jog <= 1'b0;
      repeat (4) @(posedge clk);
   endtask : t_jog

   task t_fault;
      @(posedge clk);
      fault_event <= 1'b1;
      @(posedge clk);
      fault_code <= 8'hCD;
      @(posedge clk);
      fault_event <= 1'b0;
      menu_fault <= 1'b1;
      fault_index <= 3'h1;
      i_pmj_operator.press(3);
      #1;
      chk({7'h00, disp_glyph}, {7'h00, gl(G_BLANK, 16'h00AB)});
      @(posedge clk);
      fault_index <= 3'h0;
      repeat (2) @(posedge clk);
      #1;
      chk({7'h00, disp_glyph}, {7'h00, gl(G_BLANK, 16'h00CD)});
      i_pmj_operator.press(4);
      menu_fault <= 1'b0;
   endtask : t_fault

   task t_force;
      servo_on <= 1'b0;
      wr(0, 16'h0002);
      wr(1, SFC_FORCE_ON);
      chk({28'h000_0000, force_active, dout}, 32'h0000_000A);
      wr(0, 16'h0007);
      chk({29'h000_0000, dout}, 32'h0000_0007);
      servo_on <= 1'b1;
      do_function_state <= 3'h6;
      wr(1, 16'h0123);
      chk({28'h000_0000, force_active, dout}, 32'h0000_0006);
      servo_on <= 1'b0;
      wr(1, SFC_FORCE_SWITCH);
      chk({28'h000_0000, force_active, dout}, 32'h0000_0006);
      wr(1, SFC_FORCE_ON);
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk({28'h000_0000, force_active, dout}, 32'h0000_0006);
   endtask : t_force

   // ----------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------
   initial begin
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      #1;
      chk({16'h0000, jog_speed}, {16'h0000, JOG_SPEED_RST});
      t_format();
      t_jog();
      t_fault();
      t_force();
      print_verdict();
   end

   // Whole run needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge clk);
      n_fail++;
      print_verdict();
   end
endmodule : pmj_panel_test
